/* File: common/sleep_wdt_defs.vh */
// Constants for the sleep, wake-up and watchdog controller
`ifndef SLEEP_WDT_DEFS_VH
`define SLEEP_WDT_DEFS_VH
// Register locations in expanded bank F
`define REG_PORT_CONFIG 4'h0
`define REG_WAKE_CONTROL 4'hB
`define REG_WAKE_CONTROL_TWO 4'hD
`define REG_WATCHDOG_MODE 4'hF
// Wake control fields
`define WAKE_WARM_BIT 7
`define WAKE_LEVEL_BIT 6
`define WAKE_DELAY_BIT 5
`define WAKE_SRC_HI 4
`define WAKE_SRC_LO 2
`define WAKE_DIV_BIT 0
// Wake control reset values
`define WAKE_CONTROL_RESET 8'h20
`define WAKE_CONTROL_TWO_RESET 8'h00
// Wake source codes
`define SRC_RESET_ONLY 3'h0
`define SRC_RESERVED 3'h1
`define SRC_P3_BIT1 3'h2
`define SRC_P3_BIT2 3'h3
`define SRC_P3_BIT3 3'h4
`define SRC_P2_BIT7 3'h5
`define SRC_P2_NOR_LOW 3'h6
`define SRC_P2_NOR_ALL 3'h7
// Watchdog mode fields and reset value
`define WDM_TAP_HI 1
`define WDM_TAP_LO 0
`define WDM_IDLE_BIT 2
`define WDM_SLEEP_BIT 3
`define WDM_CLKSEL_BIT 4
`define WATCHDOG_MODE_RESET 8'h0D
// Port config field
`define PCFG_CMP_BIT 0
// Timing figures
`define PWR_DELAY_MS 5
`define WDT_TAP0_MS 5
`define WDT_TAP1_MS 10
`define WDT_TAP2_MS 20
`define WDT_TAP3_MS 80
`define XTAL_TAP0 256
`define XTAL_TAP1 512
`define XTAL_TAP2 1024
`define XTAL_TAP3 4096
`define WDM_OPEN_CYCLES 61
`define FAST_WAKE_XTAL 5
`define PRESCALE_DIV 16
// Instruction opcodes
`define OP_NOP 8'hFF
`define OP_STOP 8'h6F
`define OP_HALT 8'h7F
// Restart address after deep sleep
`define RESTART_ADDR 16'h000C
`endif

/* File: hw/oneshot_counter.v */
// Loadable down counter used for the power-on delay and watchdog
`timescale 1ns/1ps
module oneshot_counter #(
	parameter W = 24
) (
	input wire clk,
	input wire rstn,
	input wire tick,
	input wire load,
	input wire [W-1:0] load_val,
	input wire hold,
	output reg busy_r,
	output reg done_r
);
	reg [W-1:0] cnt_r;

	// Counts on tick; load wins over expiry so a refresh is never lost
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= {W{1'b0}};
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (load) begin
				cnt_r <= load_val;
				busy_r <= 1'b1;
			end else if (busy_r && tick && !hold) begin
				if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
				end else begin
					cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

/* File: hw/stop_recovery_watchdog_ctrl.v */
// Sleep, wake-up, power-on delay and watchdog control for a small core
`timescale 1ns/1ps
`include "sleep_wdt_defs.vh"
module stop_recovery_watchdog_ctrl #(
	parameter CLK_MHZ = 100,
	parameter RC_KHZ = 1000,
	parameter PWR_DELAY_RC = `PWR_DELAY_MS * RC_KHZ,
	parameter WDT_TAP0_RC = `WDT_TAP0_MS * RC_KHZ,
	parameter WDT_TAP1_RC = `WDT_TAP1_MS * RC_KHZ,
	parameter WDT_TAP2_RC = `WDT_TAP2_MS * RC_KHZ,
	parameter WDT_TAP3_RC = `WDT_TAP3_MS * RC_KHZ
) (
	input wire core_clk,
	input wire rstn,
	input wire power_good,
	input wire ext_reset_n,
	input wire rc_tick,
	input wire crystal_tick,
	input wire reg_wr,
	input wire reg_rd,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata_r,
	input wire instr_valid,
	input wire [7:0] instr_op,
	input wire instr_watchdog,
	input wire irq_serviced,
	input wire analog_mode,
	input wire [7:0] port2_in,
	input wire [7:0] port2_is_output,
	input wire [3:1] port3_in,
	input wire [1:0] cmp_out,
	input wire [1:0] port3_gpio_out,
	output reg [1:0] port3_hi_out_r,
	output reg cpu_clk_en_r,
	output reg osc_en_r,
	output reg cpu_reset_r,
	output reg [15:0] restart_addr_r,
	output reg prescale_en_r,
	output reg prescale_tick_r,
	output reg irq_one_req_r,
	output reg [2:0] wdt_flags_r,
	output reg wdt_flags_we_r
);
	localparam ST_RUN = 2'h0;
	localparam ST_IDLE = 2'h1;
	localparam ST_SLEEP = 2'h2;
	localparam ST_DELAY = 2'h3;
	localparam CW = 24;
	localparam XT0 = `XTAL_TAP0, XT1 = `XTAL_TAP1, XT2 = `XTAL_TAP2, XT3 = `XTAL_TAP3;
	localparam OPEN_N = `WDM_OPEN_CYCLES;

	reg [1:0] state_r;
	reg [7:0] wake_r;
	reg [7:0] wake2_r;
	reg [7:0] wdm_r;
	reg pcfg_r, warm_r, wdt_on_r;
	reg [6:0] open_cnt_r;
	reg [3:0] pre_cnt_r;
	reg pg_d_r, wake_d_r;
	reg [2:0] fast_cnt_r;
	reg delay_load;
	reg [CW-1:0] wdt_val;
	reg src1_hit, src2_hit;
	wire wdt_tick, wdt_hold, wdt_busy, wdt_expire;
	wire dly_busy, dly_done;
	wire [7:0] p2_live;
	wire p2_any_low, p2_any_all;
	wire wake_lvl, wake_evt;
	wire wdm_open, wr_wake, start_cycle;

	// Output-configured port bits drop out of every wake term
	assign p2_live = port2_in & ~port2_is_output;
	assign p2_any_low = |(~port2_is_output[3:0]); // No live input, no NOR wake
	assign p2_any_all = |(~port2_is_output);
	assign wake_lvl = wake_r[`WAKE_LEVEL_BIT];
	assign wdm_open = (open_cnt_r != 7'd0);
	assign wr_wake = reg_wr && reg_addr == `REG_WAKE_CONTROL;
	assign start_cycle = (state_r == ST_RUN) && !cpu_reset_r;

	// Wake source decode
	always @* begin
		case (wake_r[`WAKE_SRC_HI:`WAKE_SRC_LO])
		`SRC_P3_BIT1: src1_hit = port3_in[1] == wake_lvl;
		`SRC_P3_BIT2: src1_hit = port3_in[2] == wake_lvl;
		`SRC_P3_BIT3: src1_hit = port3_in[3] == wake_lvl;
		`SRC_P2_BIT7: src1_hit = !port2_is_output[7] && (port2_in[7] == wake_lvl);
		`SRC_P2_NOR_LOW: src1_hit = p2_any_low && ((~|p2_live[3:0]) == wake_lvl);
		`SRC_P2_NOR_ALL: src1_hit = p2_any_all && ((~|p2_live) == wake_lvl);
		default: src1_hit = 1'b0;
		endcase
	end

	// Second register uses the same code layout on port 2 only
	always @* begin
		case (wake2_r[`WAKE_SRC_HI:`WAKE_SRC_LO])
		`SRC_P2_BIT7: src2_hit = !port2_is_output[7] &&
			(port2_in[7] == wake2_r[`WAKE_LEVEL_BIT]);
		`SRC_P2_NOR_LOW: src2_hit = p2_any_low &&
			((~|p2_live[3:0]) == wake2_r[`WAKE_LEVEL_BIT]);
		`SRC_P2_NOR_ALL: src2_hit = p2_any_all &&
			((~|p2_live) == wake2_r[`WAKE_LEVEL_BIT]);
		default: src2_hit = 1'b0;
		endcase
	end

	assign wake_evt = src1_hit | src2_hit;

	// Watchdog tap reload value from mode bits
	always @* begin
		if (wdm_r[`WDM_CLKSEL_BIT]) begin
			case (wdm_r[`WDM_TAP_HI:`WDM_TAP_LO])
			2'h0: wdt_val = XT0[CW-1:0];
			2'h1: wdt_val = XT1[CW-1:0];
			2'h2: wdt_val = XT2[CW-1:0];
			default: wdt_val = XT3[CW-1:0];
			endcase
		end else begin
			case (wdm_r[`WDM_TAP_HI:`WDM_TAP_LO])
			2'h0: wdt_val = WDT_TAP0_RC[CW-1:0];
			2'h1: wdt_val = WDT_TAP1_RC[CW-1:0];
			2'h2: wdt_val = WDT_TAP2_RC[CW-1:0];
			default: wdt_val = WDT_TAP3_RC[CW-1:0];
			endcase
		end
	end

	// Counter chain clock is RC or crystal input
	assign wdt_tick = wdm_r[`WDM_CLKSEL_BIT] ? crystal_tick : rc_tick;
	// Sleep counting only works on RC since crystal stops
	assign wdt_hold = (state_r == ST_IDLE && !wdm_r[`WDM_IDLE_BIT]) ||
		(state_r == ST_SLEEP && (!wdm_r[`WDM_SLEEP_BIT] || wdm_r[`WDM_CLKSEL_BIT]));

	oneshot_counter #(.W(CW)) watchdog_cnt (
		.clk(core_clk),
		.rstn(rstn),
		.tick(wdt_tick),
		.load(instr_valid && instr_watchdog && !cpu_reset_r),
		.load_val(wdt_val),
		.hold(wdt_hold),
		.busy_r(wdt_busy),
		.done_r(wdt_expire)
	);

	oneshot_counter #(.W(CW)) power_delay (
		.clk(core_clk),
		.rstn(rstn),
		.tick(rc_tick),
		.load(delay_load),
		.load_val(PWR_DELAY_RC[CW-1:0]),
		.hold(1'b0),
		.busy_r(dly_busy),
		.done_r(dly_done)
	);

	// Delay trigger: power-good rise, watchdog expiry, slow wake
	always @* begin
		delay_load = (power_good && !pg_d_r) || (wdt_expire && wdt_on_r) ||
			(state_r == ST_SLEEP && wake_evt && wake_r[`WAKE_DELAY_BIT]);
	end

	// Main power-state machine
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= ST_DELAY;
			cpu_clk_en_r <= 1'b0;
			osc_en_r <= 1'b1;
			cpu_reset_r <= 1'b1;
			restart_addr_r <= 16'h0000;
			warm_r <= 1'b0;
			wdt_on_r <= 1'b0;
			open_cnt_r <= 7'd0;
			pg_d_r <= 1'b0;
			wake_d_r <= 1'b0;
			fast_cnt_r <= 3'd0;
		end else begin
			pg_d_r <= power_good;
			wake_d_r <= src1_hit; // Only the first register feeds interrupt one
			// Window counts processor cycles after each start
			if (start_cycle && wdm_open)
				open_cnt_r <= open_cnt_r - 7'd1;
			if (instr_valid && instr_watchdog && !cpu_reset_r)
				wdt_on_r <= 1'b1;
			if (!power_good || !ext_reset_n || (power_good && !pg_d_r)) begin
				// Cold start clears the warm flag
				state_r <= ST_DELAY;
				cpu_clk_en_r <= 1'b0;
				osc_en_r <= 1'b1;
				cpu_reset_r <= 1'b1;
				warm_r <= 1'b0;
				wdt_on_r <= 1'b0;
				restart_addr_r <= (state_r == ST_SLEEP) ? `RESTART_ADDR : 16'h0000;
			end else if (wdt_expire && wdt_on_r) begin
				// Watchdog reset; warm only if it fired during sleep
				state_r <= ST_DELAY;
				cpu_clk_en_r <= 1'b0;
				osc_en_r <= 1'b1;
				cpu_reset_r <= 1'b1;
				wdt_on_r <= 1'b0;
				if (state_r != ST_SLEEP)
					warm_r <= 1'b0;
				restart_addr_r <= (state_r == ST_SLEEP) ? `RESTART_ADDR : 16'h0000;
			end else begin
				case (state_r)
				ST_RUN: begin
					// Opcode pipeline flush is the core's duty
					if (instr_valid && instr_op == `OP_STOP) begin
						state_r <= ST_SLEEP;
						cpu_clk_en_r <= 1'b0;
						osc_en_r <= 1'b0;
						warm_r <= 1'b1;
					end else if (instr_valid && instr_op == `OP_HALT) begin
						state_r <= ST_IDLE;
						cpu_clk_en_r <= 1'b0;
					end
				end
				ST_IDLE: begin
					if (irq_serviced) begin
						state_r <= ST_RUN;
						cpu_clk_en_r <= 1'b1;
					end
				end
				ST_SLEEP: begin
					fast_cnt_r <= (wake_evt && crystal_tick) ?
						fast_cnt_r + 3'd1 : (wake_evt ? fast_cnt_r : 3'd0);
					if (wake_evt && wake_r[`WAKE_DELAY_BIT]) begin
						state_r <= ST_DELAY;
						osc_en_r <= 1'b1;
						cpu_reset_r <= 1'b1;
						restart_addr_r <= `RESTART_ADDR;
					end else if (wake_evt && fast_cnt_r >= `FAST_WAKE_XTAL) begin
						// Fast wake, source held long enough
						state_r <= ST_RUN;
						osc_en_r <= 1'b1;
						cpu_clk_en_r <= 1'b1;
						cpu_reset_r <= 1'b0;
						restart_addr_r <= `RESTART_ADDR;
						open_cnt_r <= OPEN_N[6:0];
					end
				end
				ST_DELAY: begin
					fast_cnt_r <= 3'd0;
					if (!dly_busy && !delay_load) begin
						state_r <= ST_RUN;
						cpu_clk_en_r <= 1'b1;
						cpu_reset_r <= 1'b0;
						open_cnt_r <= OPEN_N[6:0];
					end
				end
				default: state_r <= ST_DELAY;
				endcase
			end
		end
	end

	// Register writes; mode register locks after the window
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			wake_r <= `WAKE_CONTROL_RESET;
			wake2_r <= `WAKE_CONTROL_TWO_RESET;
			wdm_r <= `WATCHDOG_MODE_RESET;
			pcfg_r <= 1'b0;
		end else begin
			if (!power_good) begin
				wake_r <= `WAKE_CONTROL_RESET;
				wake2_r <= `WAKE_CONTROL_TWO_RESET;
				wdm_r <= `WATCHDOG_MODE_RESET;
			end else if (state_r == ST_SLEEP && wake_evt) begin
				wake_r[`WAKE_DIV_BIT] <= 1'b0;
			end else if (wr_wake) begin
				wake_r[6:0] <= reg_wdata[6:0];
			end
			if (reg_wr && reg_addr == `REG_WAKE_CONTROL_TWO)
				wake2_r <= reg_wdata;
			if (reg_wr && reg_addr == `REG_WATCHDOG_MODE && wdm_open)
				wdm_r <= {3'b000, reg_wdata[4:0]};
			if (reg_wr && reg_addr == `REG_PORT_CONFIG)
				pcfg_r <= reg_wdata[`PCFG_CMP_BIT];
		end
	end

	// Readback: only the warm flag is visible
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			reg_rdata_r <= 8'h00;
		else if (reg_rd && reg_addr == `REG_WAKE_CONTROL)
			reg_rdata_r <= {warm_r, 7'h00};
		else
			reg_rdata_r <= 8'h00;
	end

	// Comparator routing, prescaler, interrupt one and flag strobe
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			port3_hi_out_r <= 2'b00;
			prescale_en_r <= 1'b0;
			prescale_tick_r <= 1'b0;
			pre_cnt_r <= 4'h0;
			irq_one_req_r <= 1'b0;
			wdt_flags_r <= 3'b000;
			wdt_flags_we_r <= 1'b0;
		end else begin
			port3_hi_out_r <= pcfg_r ? cmp_out : port3_gpio_out;
			prescale_en_r <= wake_r[`WAKE_DIV_BIT];
			pre_cnt_r <= pre_cnt_r + 4'h1;
			prescale_tick_r <= !wake_r[`WAKE_DIV_BIT] || (pre_cnt_r == 4'hF);
			// Falling edge of the non-port-3 sources
			irq_one_req_r <= analog_mode && wake_d_r && !src1_hit &&
				wake_r[`WAKE_SRC_HI:`WAKE_SRC_LO] >= `SRC_P2_BIT7;
			// Zero set, sign and overflow cleared on refresh
			wdt_flags_we_r <= instr_valid && instr_watchdog && !cpu_reset_r;
			wdt_flags_r <= 3'b100;
		end
	end
endmodule

/* File: verification/sleep_ctrl_assertions.sv */
// Port-level checks for the sleep, wake and watchdog controller
`timescale 1ns/1ps
module sleep_ctrl_assertions (
	input wire core_clk,
	input wire rstn,
	input wire reg_wr,
	input wire reg_rd,
	input wire [3:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata_r,
	input wire instr_valid,
	input wire [7:0] instr_op,
	input wire instr_watchdog,
	input wire irq_serviced,
	input wire [1:0] cmp_out,
	input wire [1:0] port3_gpio_out,
	input wire [1:0] port3_hi_out_r,
	input wire cpu_clk_en_r,
	input wire osc_en_r,
	input wire cpu_reset_r,
	input wire [15:0] restart_addr_r,
	input wire prescale_en_r,
	input wire prescale_tick_r,
	input wire [2:0] wdt_flags_r,
	input wire wdt_flags_we_r
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	reg [1:0] up_r;
	reg cfg_r;
	wire run = cpu_clk_en_r && !cpu_reset_r;
	// Settle count keeps reset values out of the steady-state checks
	always @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			up_r <= 2'h0;
			cfg_r <= 1'b0;
		end else begin
			if (up_r != 2'h3) up_r <= up_r + 2'h1;
			if (reg_wr && reg_addr == 4'h0) cfg_r <= reg_wdata[0];
		end
	end
	a_halt_gates_clock: assert property (run && instr_valid && instr_op == 8'h7F
		|=> !cpu_clk_en_r && osc_en_r) else $error("halt left the clock on");
	a_idle_exit_irq: assert property (!cpu_clk_en_r && osc_en_r && !cpu_reset_r &&
		!irq_serviced |=> !cpu_clk_en_r) else $error("idle left without interrupt");
	a_stop_kills_osc: assert property (run && instr_valid && instr_op == 8'h6F
		|=> !osc_en_r && !cpu_clk_en_r) else $error("stop left a clock on");
	a_stop_restart: assert property ($rose(osc_en_r) |-> restart_addr_r == 16'h000C)
		else $error("wrong restart address");
	a_flags_update: assert property (run && instr_valid && instr_watchdog
		|=> wdt_flags_we_r && wdt_flags_r == 3'h4) else $error("flags not updated");
	a_cmp_route_out: assert property (up_r == 2'h3 && !$past(reg_wr) && $stable(cmp_out) &&
		$stable(port3_gpio_out) |-> port3_hi_out_r == (cfg_r ? cmp_out : port3_gpio_out))
		else $error("port3 routing wrong");
	a_rdata_warm: assert property (reg_rd && reg_addr == 4'hB |=> reg_rdata_r[6:0] == 7'h00)
		else $error("wake read shows write-only bits");
	a_rdata_hidden: assert property (reg_rd && reg_addr != 4'hB |=> reg_rdata_r == 8'h00)
		else $error("hidden register readable");
	a_prescale_off: assert property (up_r == 2'h3 && !prescale_en_r && !$past(prescale_en_r)
		|-> prescale_tick_r) else $error("tick missing without divider");
	a_prescale_gap: assert property (prescale_en_r && prescale_tick_r ##1 prescale_en_r
		|-> !prescale_tick_r) else $error("divider ticks back to back");
endmodule
bind stop_recovery_watchdog_ctrl sleep_ctrl_assertions chk_i (.*);

/* File: verification/core_pins_model.sv */
// Core and oscillator stand-in: clock ticks and instruction issue
`timescale 1ns/1ps
module core_pins_model (
	input wire core_clk,
	input wire cpu_reset_r,
	input wire req,
	input wire [7:0] req_op,
	input wire req_wd,
	output reg rc_tick = 1'b0,
	output reg crystal_tick = 1'b0,
	output reg instr_valid = 1'b0,
	output reg [7:0] instr_op = 8'h00,
	output reg instr_watchdog = 1'b0
);
	reg [1:0] cnt_r = 2'h0;
	reg pend_r = 1'b0;
	// Falling-edge drive so the controller samples settled values
	always @(negedge core_clk) begin
		cnt_r <= cnt_r + 2'h1;
		rc_tick <= (cnt_r == 2'h3);
		crystal_tick <= cnt_r[0];
		instr_valid <= 1'b0;
		instr_watchdog <= 1'b0;
		instr_op <= {cnt_r, cnt_r, cnt_r, cnt_r}; // Idle opcode keeps moving
		if (pend_r) begin
			instr_valid <= 1'b1;
			instr_op <= req_op;
			instr_watchdog <= req_wd;
			pend_r <= 1'b0;
		end else if (req && !cpu_reset_r) begin
			instr_valid <= 1'b1;
			instr_op <= 8'hFF;
			pend_r <= 1'b1;
		end
	end
endmodule

/* File: verification/tb.sv */
// Self-checking bench for the sleep, wake and watchdog controller
`timescale 1ns/1ps
module tb;
	reg core_clk = 1'b0;
	reg rstn = 1'b0;
	reg power_good = 1'b0;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg [3:0] reg_addr = 4'h0;
	reg [7:0] reg_wdata = 8'h00;
	reg irq_serviced = 1'b0;
	reg [7:0] port2_in = 8'h00;
	reg [7:0] port2_is_output = 8'h00;
	reg [3:1] port3_in = 3'h0;
	reg [1:0] cmp_out = 2'h0;
	reg [1:0] port3_gpio_out = 2'h0;
	reg req = 1'b0;
	reg req_wd = 1'b0;
	reg [7:0] req_op = 8'h00;
	reg [31:0] seed = 32'h0000_b9e4;
	reg rd_q = 1'b0;
	reg [7:0] exp_rd[$];
	reg [2:0] exp_fl[$];
	integer miscompares = 0;
	integer num_checks = 0;
	integer n;
	integer i;
	reg ext_reset_n = 1'b1;
	reg analog_mode = 1'b0;
	wire rc_tick, crystal_tick, instr_valid, instr_watchdog;
	wire [7:0] instr_op, reg_rdata_r;
	wire [1:0] port3_hi_out_r;
	wire cpu_clk_en_r, osc_en_r, cpu_reset_r, prescale_en_r, prescale_tick_r;
	wire irq_one_req_r, wdt_flags_we_r;
	wire [15:0] restart_addr_r;
	wire [2:0] wdt_flags_r;
	// Short counts: 20 RC ticks of delay, 20/40/80/160 for the taps
	stop_recovery_watchdog_ctrl #(.PWR_DELAY_RC(20), .WDT_TAP0_RC(20), .WDT_TAP1_RC(40),
		.WDT_TAP2_RC(80), .WDT_TAP3_RC(160)) DUT (.*);
	core_pins_model core_i (.*);
	always #5 core_clk = ~core_clk;
	function [31:0] xs(input [31:0] s);
		reg [31:0] t;
		begin
			t = s ^ (s << 13);
			t = t ^ (t >> 17);
			xs = t ^ (t << 5);
		end
	endfunction
	task chk(input [15:0] got, input [15:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [3:0] a, input [7:0] d);
		begin
			@(negedge core_clk);
			reg_addr = a;
			reg_wdata = d;
			reg_wr = 1'b1;
			@(negedge core_clk);
			reg_wr = 1'b0;
		end
	endtask
	task rd(input [3:0] a, input [7:0] e);
		begin
			@(negedge core_clk);
			reg_addr = a;
			reg_rd = 1'b1;
			exp_rd.push_back(e);
			@(negedge core_clk);
			reg_rd = 1'b0;
			@(negedge core_clk);
		end
	endtask
	// Request is an NBA so the model sees it at exactly one edge
	task op(input [7:0] o, input w);
		begin
			@(negedge core_clk);
			req_op <= o;
			req_wd <= w;
			req <= 1'b1;
			@(negedge core_clk);
			req <= 1'b0;
			repeat (3) @(negedge core_clk);
		end
	endtask
	task wait_for(input want, input integer lim);
		begin
			n = 0;
			while (((cpu_clk_en_r === 1'b1) && (cpu_reset_r === 1'b0)) !== want && n < lim) begin
				@(negedge core_clk);
				n = n + 1;
			end
		end
	endtask
	task print_verdict;
		begin
			$display("Checks %0d, mismatches %0d", num_checks, miscompares);
			if (miscompares == 0 && num_checks > 0) begin
				$display("verification passed");
			end else begin
				$display("verification failed");
			end
			$finish;
		end
	endtask
	// Read answers stand one cycle; oldest note matches each result
	always @(posedge core_clk) begin
		rd_q <= reg_rd;
		if (rd_q && exp_rd.size() > 0) chk(reg_rdata_r, exp_rd.pop_front());
		if (wdt_flags_we_r === 1'b1 && exp_fl.size() > 0) chk(wdt_flags_r, exp_fl.pop_front());
	end
	// Hang guard, about ten times the thousand or so cycles the run needs
	initial begin
		#100000;
		miscompares = miscompares + 1;
		print_verdict;
	end
	initial begin
		repeat (20) @(negedge core_clk);
		rstn = 1'b1;
		@(negedge core_clk);
		power_good = 1'b1;
		wait_for(1'b1, 400);
		chk(n >= 70 && n <= 95, 1'b1);
		rd(4'hB, 8'h00);
		rd(4'hF, 8'h00);
		rd(4'h3, 8'h00);
		for (i = 0; i < 4; i = i + 1) begin
			seed = xs(seed);
			cmp_out = seed[1:0];
			port3_gpio_out = seed[3:2];
			wr(4'h0, {7'h00, i[0]});
			repeat (2) @(negedge core_clk);
			chk(port3_hi_out_r, i[0] ? cmp_out : port3_gpio_out);
		end
		op(8'h7F, 1'b0);
		repeat (20) @(negedge core_clk);
		chk({cpu_clk_en_r, osc_en_r}, 2'h1);
		irq_serviced = 1'b1;
		@(negedge core_clk);
		irq_serviced = 1'b0;
		wait_for(1'b1, 10);
		chk(n <= 3, 1'b1);
		wr(4'hB, 8'h69);
		repeat (2) @(negedge core_clk);
		chk(prescale_en_r, 1'b1);
		op(8'h6F, 1'b0);
		chk(osc_en_r, 1'b0);
		port3_in = 3'h1;
		wait_for(1'b1, 400);
		port3_in = 3'h0;
		chk(n >= 70 && n <= 100, 1'b1);
		chk(restart_addr_r, 16'h000C);
		chk(prescale_en_r, 1'b0);
		rd(4'hB, 8'h80);
		// Reserved code, fast wake; second source on port2 bit7 high
		wr(4'hB, 8'h04);
		wr(4'hD, 8'h54);
		seed = xs(seed);
		port2_is_output = 8'h80;
		port2_in = {1'b1, seed[6:0]};
		op(8'h6F, 1'b0);
		wait_for(1'b1, 60);
		chk(n == 60, 1'b1);
		port2_is_output = 8'h00;
		wait_for(1'b1, 60);
		chk(n < 40, 1'b1);
		port2_in = 8'h00;
		// Window is long shut: the tap write must not take
		repeat (80) @(negedge core_clk);
		wr(4'hF, 8'h00);
		exp_fl.push_back(3'h4);
		op(8'h5F, 1'b1);
		repeat (60) @(negedge core_clk);
		exp_fl.push_back(3'h4);
		op(8'h5F, 1'b1);
		wait_for(1'b0, 400);
		chk(n >= 145 && n <= 170, 1'b1);
		wait_for(1'b1, 400);
		chk(n >= 70 && n <= 95, 1'b1);
		rd(4'hB, 8'h00);
		// External reset is cold, needs no delay and reopens the mode window
		ext_reset_n = 1'b0;
		@(negedge core_clk);
		chk(cpu_reset_r, 1'b1);
		ext_reset_n = 1'b1;
		wait_for(1'b1, 10);
		chk(restart_addr_r, 16'h0000);
		wr(4'hF, 8'h00);
		exp_fl.push_back(3'h4);
		op(8'h5F, 1'b1);
		wait_for(1'b0, 400);
		chk(n >= 65 && n <= 90, 1'b1);
		wait_for(1'b1, 400);
		// Interrupt one follows the falling edge of a port 2 source
		analog_mode = 1'b1;
		wr(4'hB, 8'h54);
		port2_in = 8'h80;
		repeat (2) @(negedge core_clk);
		port2_in = 8'h00;
		@(negedge core_clk);
		chk(irq_one_req_r, 1'b1);
		@(negedge core_clk);
		chk(irq_one_req_r, 1'b0);
		print_verdict;
	end
endmodule
